// ===== verilog/boot_image_loader.sv
// Function
// - Strap high at reset starts boot at zero
// - Check first 32 bytes as eight vectors
// - Sixth vector skipped, holds size and geometry
// - Condition field must be hex E
// - Branch pattern 1010, offset unconstrained
// - Load needs base, dest PC, L, P
// - Blocks field times 512 is length
// - Page count is two to the exponent
// - Top 15 bits give flash page size
// - Size field sets length for every source
// - Valid image copied, then remapped and jumped to in the same cycle
// - No valid image starts serial/USB upload
// - After reset ROM at zero and high
// - Probe flash, then EEPROM, then parallel
// - EEPROM at address zero, ack means present
// - Non-flash sources ignore geometry fields
// - After remap SRAM at zero, ROM high
`timescale 1ns/1ps
`default_nettype none
module boot_image_loader (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic                         boot_source_select_pin,
  output boot_loader_pkg::read_cmd_type     rd_cmd,
  output logic                              rd_req,
  input  wire logic                         rd_valid,
  input  wire logic                         rd_nak,
  input  wire logic [7:0]                   rd_data,
  output logic                              serial_periph_select_zero_n,
  output logic                              external_chip_select_zero_n,
  output boot_loader_pkg::sram_wr_type      sram_wr,
  output logic                              sram_wr_valid,
  input  wire logic                         sram_wr_ready,
  output logic                              upload_enable,
  input  wire logic                         upload_done,
  output logic                              rom_at_zero,
  output logic                              rom_at_high,
  output logic                              cpu_start,
  output logic [31:0]                       cpu_start_addr,
  output logic                              boot_active
);
  typedef enum logic [3:0] {
    S_STRAP, S_OFF, S_PROBE, S_CHECK, S_COPY, S_DRAIN,
    S_UPLOAD, S_REMAP, S_RUN
  } state_type;

  state_type                    state;
  state_type                    next_state;
  boot_loader_pkg::src_type     src;
  logic [7:0]                   vec_byte [boot_loader_pkg::VEC_BYTES];
  logic [16:0]                  byte_cnt;
  logic [16:0]                  copy_len;
  logic [14:0]                  pg_off;
  logic [15:0]                  pg_idx;
  logic [14:0]                  page_size;
  logic [15:0]                  page_mask;
  logic [23:0]                  word_acc;
  logic [1:0]                   lane;
  logic                         word_full;
  logic [31:0]                  word_data;
  logic [14:0]                  wr_addr;
  logic                         fifo_out_valid;
  logic [31:0]                  fifo_out_data;
  logic                         fifo_in_ready;
  logic [31:0]                  vec   [boot_loader_pkg::VEC_COUNT];
  logic [boot_loader_pkg::VEC_COUNT-1:0] vec_ok;

  // Vectors are stored little-endian, one byte per read
  genvar g;
  generate
    for (g = 0; g < boot_loader_pkg::VEC_COUNT; g++) begin : gen_vec
      wire [31:0] w = {vec_byte[4*g+3], vec_byte[4*g+2],
                       vec_byte[4*g+1], vec_byte[4*g]};
      wire cond_ok  = w[31:28] == boot_loader_pkg::COND_ALWAYS;
      wire is_b     = w[27:24] == boot_loader_pkg::BRANCH_PATTERN;
      // Write-back and up/down bits are left free on purpose
      wire is_ldr   = w[27:26] == 2'b01 &&
                      w[boot_loader_pkg::PREINDEX_BIT] &&
                      w[boot_loader_pkg::LOAD_BIT] &&
                      w[19:16] == boot_loader_pkg::PC_REG &&
                      w[15:12] == boot_loader_pkg::PC_REG;
      assign vec[g]    = w;
      assign vec_ok[g] = (g == boot_loader_pkg::INFO_VEC) ||
                         (cond_ok && (is_b || is_ldr));
    end
  endgenerate

  wire [31:0] info       = vec[boot_loader_pkg::INFO_VEC];
  wire        image_ok   = &vec_ok;
  // Only the low size byte and geometry are decoded; 12..8 unused
  wire [16:0] size_bytes = {1'b0, info[boot_loader_pkg::SIZE_MSB:
                           boot_loader_pkg::SIZE_LSB], 8'h00} << 1;
  wire [3:0]  page_exp   = info[boot_loader_pkg::PAGES_MSB:
                                boot_loader_pkg::PAGES_LSB];
  wire [14:0] psize_fld  = info[boot_loader_pkg::PSIZE_MSB:
                                boot_loader_pkg::PSIZE_LSB];
  wire [15:0] exp_mask   = 16'(({1'b0, 16'h0001} << page_exp) - 17'd1);
  wire        in_fetch   = state == S_PROBE || state == S_COPY;
  wire        answer     = rd_req && (rd_valid || rd_nak);
  wire        got_byte   = rd_req && rd_valid;
  wire        probe_last = byte_cnt == 17'(boot_loader_pkg::VEC_BYTES - 1);
  wire        copy_last  = byte_cnt == copy_len - 17'd1;
  wire        push       = word_full && fifo_in_ready;
  wire        out_free   = !sram_wr_valid || sram_wr_ready;
  wire        page_wrap  = pg_off == page_size - 15'd1;
  wire        issue      = in_fetch && !rd_req && !word_full &&
                           next_state == state;
  wire        all_drained = !word_full && !fifo_out_valid &&
                            !sram_wr_valid;
  wire [16:0] next_addr  = byte_cnt + 17'd1;
  wire        flash_src  = src == boot_loader_pkg::SRC_FLASH;
  wire        eep_src    = src == boot_loader_pkg::SRC_EEPROM;

  always_comb begin
    next_state = state;
    unique case (state)
      S_STRAP: begin
        next_state = boot_source_select_pin ? S_PROBE : S_OFF;
      end
      S_OFF: begin
        next_state = S_OFF;
      end
      S_PROBE: begin
        if (rd_req && rd_nak) begin
          // Absent or silent source: move on in fixed order
          next_state = (src == boot_loader_pkg::SRC_PARALLEL) ?
                       S_UPLOAD : S_PROBE;
        end else if (got_byte && probe_last) begin
          next_state = S_CHECK;
        end
      end
      S_CHECK: begin
        if (!image_ok) begin
          next_state = (src == boot_loader_pkg::SRC_PARALLEL) ?
                       S_UPLOAD : S_PROBE;
        end else if (size_bytes == 17'd0) begin
          next_state = S_REMAP;
        end else begin
          next_state = S_COPY;
        end
      end
      S_COPY: begin
        if (rd_req && rd_nak) begin
          next_state = S_UPLOAD;
        end else if (got_byte && copy_last) begin
          next_state = S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (all_drained) begin
          next_state = S_REMAP;
        end
      end
      S_UPLOAD: begin
        if (upload_done) begin
          next_state = S_REMAP;
        end
      end
      S_REMAP: begin
        next_state = S_RUN;
      end
      S_RUN: begin
        next_state = S_RUN;
      end
      default: begin
        next_state = S_STRAP;
      end
    endcase
  end

  // Source order and state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_STRAP;
      src   <= boot_loader_pkg::SRC_FLASH;
    end else begin
      state <= next_state;
      if ((state == S_PROBE && next_state == S_PROBE && rd_req && rd_nak)
          || (state == S_CHECK && next_state == S_PROBE)) begin
        src <= boot_loader_pkg::src_type'(src + 2'd1);
      end
    end
  end

  // Byte counter and flash page addressing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      byte_cnt  <= '0;
      pg_off    <= '0;
      pg_idx    <= '0;
      copy_len  <= '0;
      page_size <= '1;
      page_mask <= '1;
    end else if (state == S_CHECK || next_state != state) begin
      // The copy, and a source tried after a failed check, restart at device address zero
      byte_cnt <= '0;
      pg_off   <= '0;
      pg_idx   <= '0;
      if (state == S_CHECK) begin
        copy_len  <= size_bytes;
        page_size <= psize_fld;
        page_mask <= exp_mask;
      end
    end else if (got_byte) begin
      byte_cnt <= next_addr;
      pg_off   <= page_wrap ? 15'd0 : pg_off + 15'd1;
      if (page_wrap) begin
        pg_idx <= (pg_idx + 16'd1) & page_mask;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (state == S_PROBE && got_byte) begin
      vec_byte[byte_cnt[4:0]] <= rd_data;
    end
  end

  // Read request: level held until answered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_req <= 1'b0;
      rd_cmd <= '0;
    end else begin
      if (answer) begin
        rd_req <= 1'b0;
      end else if (issue) begin
        rd_req        <= 1'b1;
        rd_cmd.src    <= src;
        rd_cmd.dev    <= eep_src ? boot_loader_pkg::TWO_WIRE_DEV
                                 : 7'h00;
        rd_cmd.addr   <= byte_cnt;
        // Geometry is only meaningful for the serial flash
        rd_cmd.page   <= flash_src ? pg_idx : 16'h0000;
        rd_cmd.offset <= flash_src ? pg_off : 15'h0000;
      end
    end
  end

  // Byte packing, little-endian into words
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      word_acc  <= '0;
      lane      <= '0;
      word_full <= 1'b0;
      word_data <= '0;
    end else begin
      if (push) begin
        word_full <= 1'b0;
      end
      if (state == S_COPY && got_byte) begin
        lane <= lane + 2'd1;
        if (lane == 2'd3) begin
          word_data <= {rd_data, word_acc};
          word_full <= 1'b1;
        end else begin
          word_acc <= {rd_data, word_acc[23:8]};
        end
      end
    end
  end

  word_fifo #(
    .WIDTH (boot_loader_pkg::FIFO_WIDTH),
    .DEPTH (boot_loader_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (word_full),
    .in_ready  (fifo_in_ready),
    .in_data   (word_data),
    .out_valid (fifo_out_valid),
    .out_ready (out_free),
    .out_data  (fifo_out_data)
  );

  // Registered SRAM write port; stalls reach the reads via the fifo
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sram_wr_valid <= 1'b0;
      sram_wr       <= '0;
      wr_addr       <= '0;
    end else if (out_free) begin
      sram_wr_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        sram_wr.data      <= fifo_out_data;
        sram_wr.word_addr <= wr_addr;
        wr_addr           <= wr_addr + 15'd1;
      end
    end
  end

  // Memory map, chip selects, upload and jump
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_at_zero                 <= 1'b1;
      rom_at_high                 <= 1'b1;
      upload_enable               <= 1'b0;
      cpu_start                   <= 1'b0;
      cpu_start_addr              <= boot_loader_pkg::RESET_VECTOR;
      boot_active                 <= 1'b0;
      serial_periph_select_zero_n <= 1'b1;
      external_chip_select_zero_n <= 1'b1;
    end else begin
      boot_active   <= state != S_STRAP && state != S_OFF &&
                       state != S_RUN;
      upload_enable <= next_state == S_UPLOAD;
      cpu_start     <= state == S_REMAP;
      if (state == S_REMAP) begin
        rom_at_zero    <= 1'b0;
        cpu_start_addr <= boot_loader_pkg::SRAM_ENTRY;
      end
      serial_periph_select_zero_n <= !(rd_req && flash_src);
      external_chip_select_zero_n <=
        !(rd_req && src == boot_loader_pkg::SRC_PARALLEL);
    end
  end
endmodule
`default_nettype wire

// ===== verilog/boot_loader_pkg.sv
`default_nettype none
package boot_loader_pkg;
  typedef enum logic [1:0] {
    SRC_FLASH, SRC_EEPROM, SRC_PARALLEL, SRC_NONE
  } src_type;
  localparam logic [31:0] RESET_VECTOR     = 32'h0000_0000;
  localparam logic [31:0] ROM_HIGH_BASE    = 32'h0010_0000;
  localparam logic [31:0] SRAM_ENTRY       = 32'h0000_0000;
  localparam int          VEC_BYTES        = 32;
  localparam int          VEC_COUNT        = 8;
  localparam int          INFO_VEC         = 5;
  localparam logic [3:0]  COND_ALWAYS      = 4'hE;
  localparam logic [3:0]  BRANCH_PATTERN   = 4'hA;
  localparam logic [3:0]  PC_REG           = 4'hF;
  localparam int          LOAD_BIT         = 20;
  localparam int          PREINDEX_BIT     = 24;
  localparam int          SIZE_LSB         = 0;
  localparam int          SIZE_MSB         = 7;
  localparam int          PAGES_LSB        = 13;
  localparam int          PAGES_MSB        = 16;
  localparam int          PSIZE_LSB        = 17;
  localparam int          PSIZE_MSB        = 31;
  localparam int          BLOCK_SHIFT      = 9;
  localparam logic [6:0]  TWO_WIRE_DEV     = 7'h00;
  localparam int          FIFO_WIDTH       = 32;
  localparam int          FIFO_DEPTH       = 32;
  typedef struct packed {
    src_type     src;
    logic [6:0]  dev;
    logic [16:0] addr;
    logic [15:0] page;
    logic [14:0] offset;
  } read_cmd_type;
  typedef struct packed {
    logic [14:0] word_addr;
    logic [31:0] data;
  } sram_wr_type;
endpackage
`default_nettype wire

// ===== verilog/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  // Extra pointer bit tells full from empty without a counter
  assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/boot_image_loader_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module boot_image_loader_monitor (
  input wire logic                          clk,
  input wire logic                          arst_n,
  input wire boot_loader_pkg::read_cmd_type rd_cmd,
  input wire logic                          rd_req,
  input wire logic                          rd_valid,
  input wire logic                          rd_nak,
  input wire logic                          serial_periph_select_zero_n,
  input wire logic                          external_chip_select_zero_n,
  input wire boot_loader_pkg::sram_wr_type  sram_wr,
  input wire logic                          sram_wr_valid,
  input wire logic                          sram_wr_ready,
  input wire logic                          upload_enable,
  input wire logic                          rom_at_zero,
  input wire logic                          rom_at_high,
  input wire logic                          cpu_start,
  input wire logic [31:0]                   cpu_start_addr,
  input wire logic                          boot_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Jump is a single pulse in the same cycle as the remap
  sequence seq_jump;
    cpu_start ##1 !cpu_start;
  endsequence
  chk_req_held:
  assert property (rd_req && !rd_valid && !rd_nak |=> rd_req && $stable(rd_cmd))
    else $error("read request not held");
  chk_first_read:
  assert property ($rose(boot_active) |-> ##[0:1] (rd_req &&
    rd_cmd.addr == 17'h0_0000 && rd_cmd.src == boot_loader_pkg::SRC_FLASH))
    else $error("first read not flash at zero");
  chk_flash_select:
  assert property (rd_req && rd_cmd.src == boot_loader_pkg::SRC_FLASH
    |=> !serial_periph_select_zero_n) else $error("flash select missing");
  chk_par_select:
  assert property (rd_req && rd_cmd.src == boot_loader_pkg::SRC_PARALLEL
    |=> !external_chip_select_zero_n) else $error("parallel select missing");
  chk_eeprom_addr:
  assert property (rd_req && rd_cmd.src == boot_loader_pkg::SRC_EEPROM
    |-> rd_cmd.dev == 7'h00) else $error("eeprom device address wrong");
  chk_geometry_off:
  assert property (rd_req && rd_cmd.src != boot_loader_pkg::SRC_FLASH
    |-> rd_cmd.page == 16'h0000 && rd_cmd.offset == 15'h0000)
    else $error("geometry used on linear source");
  chk_rom_high:
  assert property (rom_at_high) else $error("rom missing at high base");
  chk_boot_rom:
  assert property ($rose(boot_active) |-> rom_at_zero)
    else $error("rom not at zero during boot");
  chk_remap_jump:
  assert property ($fell(rom_at_zero) |-> seq_jump)
    else $error("no jump after remap");
  chk_jump_target:
  assert property (cpu_start |-> !rom_at_zero &&
    cpu_start_addr == boot_loader_pkg::SRAM_ENTRY) else $error("bad jump");
  chk_upload_quiet:
  assert property (upload_enable |-> !rd_req) else $error("read during upload");
  chk_wr_held:
  assert property (sram_wr_valid && !sram_wr_ready
    |=> sram_wr_valid && $stable(sram_wr)) else $error("sram write dropped");
endmodule
`default_nettype wire

// ===== verification/nvm_model.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_model (
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire boot_loader_pkg::read_cmd_type rd_cmd,
  input  wire logic                          rd_req,
  output logic                               rd_valid,
  output logic                               rd_nak,
  output logic [7:0]                         rd_data
);
  logic [31:0] vec [3][8];
  logic [3:0]  present;
  int          psz;
  int          wait_cnt;
  int          ba;
  logic [1:0]  s;
  logic        here;

  assign s    = rd_cmd.src;
  assign ba   = (s == 2'h0) ? rd_cmd.page * psz + rd_cmd.offset : rd_cmd.addr;
  assign here = present[s] && (s != 2'h1 || rd_cmd.dev == 7'h00);

  // Vector 5 is whatever the image provider placed there
  function automatic logic [7:0] pick(input int a);
    logic [31:0] w;
    w = vec[s][a[4:2]];
    return (a < 32) ? w[8*a[1:0] +: 8] : 8'(a * 7 + s);
  endfunction

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid <= 1'b0;
      rd_nak   <= 1'b0;
      rd_data  <= 8'hA5;
      wait_cnt <= 0;
    end else begin
      rd_valid <= 1'b0;
      rd_nak   <= 1'b0;
      // Released data is inverted so a late sample never looks right
      if (rd_valid) rd_data <= ~rd_data;
      // Odd addresses answer slowly to vary the latency
      if (rd_req && !rd_valid && !rd_nak) begin
        if (wait_cnt < (ba[0] ? 2 : 0)) begin
          wait_cnt <= wait_cnt + 1;
        end else begin
          wait_cnt <= 0;
          rd_valid <= here;
          rd_nak   <= !here;
          if (here) rd_data <= pick(ba);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
bind boot_image_loader boot_image_loader_monitor mon_u (.*);
module tb_top;
  logic clk, arst_n, boot_source_select_pin, rd_req, rd_valid, rd_nak;
  logic serial_periph_select_zero_n, external_chip_select_zero_n;
  logic sram_wr_valid, sram_wr_ready, upload_enable, upload_done;
  logic rom_at_zero, rom_at_high, cpu_start, boot_active;
  logic [7:0]                    rd_data;
  logic [31:0]                   cpu_start_addr;
  logic [1:0]                    last_src;
  boot_loader_pkg::read_cmd_type rd_cmd;
  boot_loader_pkg::sram_wr_type  sram_wr;
  int fails = 0, tests_run = 0, cycles = 0, stall_until = 0, nw, nread;
  localparam logic [31:0] GOOD [8] = '{32'hEA00_000B, 32'hE59F_F014,
    32'hE51F_FF20, 32'hE5BF_F014, 32'hEAFF_FFFF, 32'h0000_0000,
    32'hE59F_F014, 32'hE51F_FF20};

  boot_image_loader dut_u (.*);
  nvm_model nvm_u (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Ready stalls long enough for the word buffer to fill
  always @(posedge clk) begin
    cycles <= cycles + 1;
    sram_wr_ready <= (cycles >= stall_until);
    if (cycles == 30000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] exp_word(input logic [1:0] s, input int k);
    logic [31:0] w;
    w = nvm_u.vec[s][k % 8];
    if (k >= 8) w = {8'(28*k+21+s), 8'(28*k+14+s), 8'(28*k+7+s), 8'(28*k+s)};
    return w;
  endfunction

  task automatic load(input int s, input logic [31:0] v5, input int bi,
                      input logic [31:0] bw);
    for (int i = 0; i < 8; i++) nvm_u.vec[s][i] = GOOD[i];
    nvm_u.vec[s][5] = v5;
    if (bi < 8) nvm_u.vec[s][bi] = bw;
  endtask

  task automatic do_reset(input logic strap);
    @(posedge clk);
    boot_source_select_pin <= strap;
    arst_n <= 1'b0;
    repeat (12) @(posedge clk);
    check("rom_at_zero reset", 1, rom_at_zero);
    check("rom_at_high reset", 1, rom_at_high);
    stall_until = cycles + 1500;
    arst_n <= 1'b1;
  endtask

  task automatic boot_run(input logic [1:0] src, input int words,
                          input logic upl);
    int n;
    do_reset(1'b1);
    nw = 0;
    nread = 0;
    last_src = 2'h0;
    n = 0;
    while (n < 9000 && cpu_start !== 1'b1 && upload_enable !== 1'b1) begin
      @(negedge clk);
      n++;
      if (rd_req === 1'b1) begin
        check("probe order", 1, rd_cmd.src >= last_src);
        last_src = rd_cmd.src;
        if (rd_valid === 1'b1) nread++;
      end
      if (sram_wr_valid === 1'b1 && sram_wr_ready === 1'b1) begin
        check("word_addr", nw, 32'(sram_wr.word_addr));
        check("sram data", exp_word(src, nw), sram_wr.data);
        nw++;
      end
      if (words > 0 && cycles == stall_until - 2)
        check("reads stop when full", 1,
          nread <= 32 + 4 * (boot_loader_pkg::FIFO_DEPTH + 2));
    end
    check("upload", upl, upload_enable);
    check("words copied", words, nw);
    check("last source", src, last_src);
    if (!upl) check("jump address", 32'h0000_0000, cpu_start_addr);
    if (!upl) check("remapped", 0, rom_at_zero);
  endtask

  task automatic t_strap_low;
    do_reset(1'b0);
    repeat (100) @(negedge clk);
    check("idle read", 0, rd_req);
    check("idle active", 0, boot_active);
    $display("test strap low done");
  endtask

  // Reserved bits set, page size 264, one block
  task automatic t_flash;
    nvm_u.present = 4'b0001;
    load(0, 32'h0211_BF01, 8, 32'h0000_0000);
    boot_run(2'h0, 128, 1'b0);
    $display("test flash copy done");
  endtask

  // Flash absent, geometry fields hold junk
  task automatic t_eeprom;
    nvm_u.present = 4'b0010;
    load(1, 32'hFFFF_E001, 8, 32'h0000_0000);
    boot_run(2'h1, 128, 1'b0);
    $display("test eeprom copy done");
  endtask

  task automatic t_parallel;
    nvm_u.present = 4'b0111;
    load(0, 32'h0211_BF01, 0, 32'hDA00_000B);
    load(1, 32'h0000_0001, 1, 32'hE59E_F014);
    load(2, 32'h0000_0000, 8, 32'h0000_0000);
    boot_run(2'h2, 0, 1'b0);
    $display("test parallel zero size done");
  endtask

  task automatic t_upload;
    int n;
    nvm_u.present = 4'b0111;
    load(0, 32'h0211_BF01, 0, 32'hEB00_000B);
    load(1, 32'h0000_0001, 1, 32'hE49F_F014);
    load(2, 32'h0000_0001, 6, 32'hE59F_E014);
    boot_run(2'h2, 0, 1'b1);
    @(posedge clk);
    upload_done <= 1'b1;
    n = 0;
    while (n < 10 && cpu_start !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    check("upload jump", 1, cpu_start);
    check("upload remap", 0, rom_at_zero);
    @(posedge clk);
    upload_done <= 1'b0;
    $display("test upload done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    boot_source_select_pin = 1'b0;
    sram_wr_ready = 1'b0;
    upload_done = 1'b0;
    nvm_u.present = 4'b0000;
    nvm_u.psz = 264;
    t_strap_low();
    t_flash();
    t_eeprom();
    t_parallel();
    t_upload();
    tally_and_finish();
  end
endmodule
`default_nettype wire
